//--- gec_defs.svh
`ifndef GEC_DEFS_SVH
`define GEC_DEFS_SVH

// Register byte offsets
`define GEC_OFS_PIN_LEVEL   8'h00
`define GEC_OFS_OUT_DATA    8'h04
`define GEC_OFS_DIRECTION   8'h08
`define GEC_OFS_FN_ENABLE   8'h0C
`define GEC_OFS_EDGE_CFG    8'h10
`define GEC_OFS_CNT_CFG     8'h14
`define GEC_OFS_CNT_EXPIRY  8'h18
`define GEC_OFS_CNT_VALUE   8'h1C
`define GEC_OFS_ADC_CTRL    8'h20
`define GEC_OFS_ADC_LIMITS  8'h24
`define GEC_OFS_ADC_VALUE   8'h28
`define GEC_OFS_IRQ_STATUS  8'h2C
`define GEC_OFS_IRQ_MASK    8'h30
`define GEC_OFS_WDOG        8'h34

// Field positions
`define GEC_FN_CMODE_POS    4
`define GEC_NOTIFY_RISE     0
`define GEC_NOTIFY_FALL     1
`define GEC_DEB_EN_POS      2
`define GEC_CYCLIC_POS      2
`define GEC_ADC_PER_EN      0
`define GEC_ADC_THR_EN      1
`define GEC_ADC_PER_POS     8
`define GEC_ST_EDGE_POS     0
`define GEC_ST_CNT_POS      4
`define GEC_ST_PER_POS      6
`define GEC_ST_LOW_POS      7
`define GEC_ST_HIGH_POS     10
`define GEC_WDOG_ACT_POS    0
`define GEC_WDOG_KICK_POS   1

// Reset values
`define GEC_RST_EDGE_CFG    16'h7777
`define GEC_RST_CNT_CFG     8'h77
`define GEC_RST_CNT_EXPIRY  32'h0032_0032
`define GEC_RST_ADC_CTRL    16'h0100
`define GEC_RST_ADC_LIMITS  32'hC8BE_3C32

// Timing
`define GEC_CLK_HZ          25_000_000
`define GEC_DEB_TIME_MS     40
`define GEC_ADC_TICK_S      4
`define GEC_WDOG_TIME_S     32

`endif

//--- gec_pkg.sv
package gec_pkg;

	// One Avalon-MM request from the master
	typedef struct packed
	{
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} gec_av_req_t;

	// Three 8-bit converter results
	typedef logic [2:0][7:0] gec_adc_vec_t;

endpackage

//--- gec_gpio_monitor.sv
`timescale 1ns/10ps
`include "gec_defs.svh"
module gec_gpio_monitor #(
	parameter int LINES       = 16,
	parameter int DEB_CYCLES  = `GEC_DEB_TIME_MS * (`GEC_CLK_HZ / 1000),
	parameter int TICK_CYCLES = `GEC_ADC_TICK_S * `GEC_CLK_HZ,
	parameter int WDOG_CYCLES = `GEC_WDOG_TIME_S * `GEC_CLK_HZ
) (
	// Clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	// Avalon-MM slave
	input  wire gec_pkg::gec_av_req_t i_av,
	output logic                     o_av_waitrequest,
	output logic [31:0]              o_av_readdata,
	// General-purpose lines
	input  wire logic [LINES-1:0]    i_gpio_in,
	output logic [LINES-1:0]         o_gpio_out,
	output logic [LINES-1:0]         o_gpio_oe,
	// Converter results, same clock
	input  wire gec_pkg::gec_adc_vec_t i_adc_result,
	// Interrupt and system restart
	output logic                     o_irq,
	output logic                     o_sys_restart
);
	import gec_pkg::*;

	localparam int DEB_W  = $clog2(DEB_CYCLES + 1);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int WDOG_W = $clog2(WDOG_CYCLES + 1);
	localparam int ST_W   = 13;

	// Elaboration checks
	if (LINES != 16)
		$error("gec_gpio_monitor: LINES must be 16");
	if (DEB_CYCLES < 1 || TICK_CYCLES < 1 || WDOG_CYCLES < 1)
		$error("gec_gpio_monitor: counts must be at least one cycle");

	function automatic logic [31:0] wmerge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
			if (be[b])
				res[8*b +: 8] = new_v[8*b +: 8];
		return res;
	endfunction

	// Registers
	logic              wait_ff;
	logic [31:0]       rdata_ff;
	logic [LINES-1:0]  out_data_ff;
	logic [LINES-1:0]  dir_ff;
	logic [3:0]        fn_en_ff;
	logic [1:0]        cnt_mode_ff;
	logic [15:0]       edge_cfg_ff;
	logic [7:0]        cnt_cfg_ff;
	logic [31:0]       cnt_exp_ff;
	logic [15:0]       adc_ctrl_ff;
	logic [31:0]       adc_lim_ff;
	logic [ST_W-1:0]   status_ff;
	logic [ST_W-1:0]   mask_ff;
	logic [ST_W-1:0]   nxt_status;
	logic              irq_ff;
	logic [LINES-1:0]  sync1_ff;
	logic [LINES-1:0]  sync2_ff;
	logic [LINES-1:0]  sync3_ff;
	logic [LINES-1:0]  lvl_ff;
	logic [3:0]        filt_ff;
	logic [3:0]        prev_ff;
	logic [3:0]        rise_w;
	logic [3:0]        fall_w;
	logic [3:0]        edge_evt;
	logic [1:0]        cnt_evt;
	logic [1:0][15:0]  cnt_ff;
	logic [1:0]        cnt_clr;
	logic [TICK_W-1:0] tick_cnt_ff;
	logic              tick_ff;
	logic [7:0]        per_cnt_ff;
	logic              per_evt_ff;
	logic [2:0]        low_evt;
	logic [2:0]        high_evt;
	logic              wdog_act_ff;
	logic [WDOG_W-1:0] wdog_cnt_ff;
	logic              restart_ff;
	logic              wr_go;
	logic              rd_go;

	// Bus handshake: every access answers one cycle after it is seen
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
			wait_ff <= 1'b1;
		else
			wait_ff <= ~((i_av.read | i_av.write) & wait_ff);

	assign wr_go = i_av.write & ~wait_ff;
	assign rd_go = i_av.read & ~wait_ff;
	assign cnt_clr = (wr_go && i_av.address == `GEC_OFS_CNT_VALUE) ? i_av.writedata[1:0] : 2'b00;

	// Read data prepared during the waiting cycle
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
			rdata_ff <= 32'h0000_0000;
		else if (i_av.read & wait_ff)
		begin
			unique case (i_av.address)
				`GEC_OFS_PIN_LEVEL:  rdata_ff <= {16'h0000, lvl_ff};
				`GEC_OFS_OUT_DATA:   rdata_ff <= {16'h0000, out_data_ff};
				`GEC_OFS_DIRECTION:  rdata_ff <= {16'h0000, dir_ff};
				`GEC_OFS_FN_ENABLE:  rdata_ff <= {26'h0, cnt_mode_ff, fn_en_ff};
				`GEC_OFS_EDGE_CFG:   rdata_ff <= {16'h0000, edge_cfg_ff};
				`GEC_OFS_CNT_CFG:    rdata_ff <= {24'h00_0000, cnt_cfg_ff};
				`GEC_OFS_CNT_EXPIRY: rdata_ff <= cnt_exp_ff;
				`GEC_OFS_CNT_VALUE:  rdata_ff <= {cnt_ff[1], cnt_ff[0]};
				`GEC_OFS_ADC_CTRL:   rdata_ff <= {16'h0000, adc_ctrl_ff};
				`GEC_OFS_ADC_LIMITS: rdata_ff <= adc_lim_ff;
				`GEC_OFS_ADC_VALUE:  rdata_ff <= {8'h00, i_adc_result};
				`GEC_OFS_IRQ_STATUS: rdata_ff <= {19'h0, status_ff};
				`GEC_OFS_IRQ_MASK:   rdata_ff <= {19'h0, mask_ff};
				`GEC_OFS_WDOG:       rdata_ff <= {31'h0, wdog_act_ff};
				default:             rdata_ff <= 32'h0000_0000;
			endcase
		end

	// Software-written configuration
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			out_data_ff <= '0;
			dir_ff      <= '0;
			fn_en_ff    <= 4'h0;
			cnt_mode_ff <= 2'b00;
			edge_cfg_ff <= `GEC_RST_EDGE_CFG;
			cnt_cfg_ff  <= `GEC_RST_CNT_CFG;
			cnt_exp_ff  <= `GEC_RST_CNT_EXPIRY;
			adc_ctrl_ff <= `GEC_RST_ADC_CTRL;
			adc_lim_ff  <= `GEC_RST_ADC_LIMITS;
			mask_ff     <= '0;
		end
		else if (wr_go)
		begin
			unique case (i_av.address)
				`GEC_OFS_OUT_DATA:
					out_data_ff <= LINES'(wmerge({16'h0, out_data_ff}, i_av.writedata,
						i_av.byteenable));
				`GEC_OFS_DIRECTION:
					dir_ff <= LINES'(wmerge({16'h0, dir_ff}, i_av.writedata,
						i_av.byteenable));
				`GEC_OFS_FN_ENABLE:
					if (i_av.byteenable[0])
					begin
						fn_en_ff    <= i_av.writedata[3:0];
						cnt_mode_ff <= i_av.writedata[`GEC_FN_CMODE_POS +: 2];
					end
				`GEC_OFS_EDGE_CFG:
					edge_cfg_ff <= 16'(wmerge({16'h0, edge_cfg_ff}, i_av.writedata,
						i_av.byteenable));
				`GEC_OFS_CNT_CFG:
					if (i_av.byteenable[0])
						cnt_cfg_ff <= i_av.writedata[7:0];
				`GEC_OFS_CNT_EXPIRY:
					cnt_exp_ff <= wmerge(cnt_exp_ff, i_av.writedata, i_av.byteenable);
				`GEC_OFS_ADC_CTRL:
					adc_ctrl_ff <= 16'(wmerge({16'h0, adc_ctrl_ff}, i_av.writedata,
						i_av.byteenable));
				`GEC_OFS_ADC_LIMITS:
					adc_lim_ff <= wmerge(adc_lim_ff, i_av.writedata, i_av.byteenable);
				`GEC_OFS_IRQ_MASK:
					mask_ff <= ST_W'(wmerge({19'h0, mask_ff}, i_av.writedata,
						i_av.byteenable));
				default:
					;
			endcase
		end

	// Pin inputs: three flops, accept when stages two and three agree
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
			lvl_ff   <= '0;
		end
		else
		begin
			sync1_ff <= i_gpio_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			for (int i = 0; i < LINES; i++)
				if (sync2_ff[i] == sync3_ff[i])
					lvl_ff[i] <= sync3_ff[i];
		end

	// Edge-capable channels: index 0..3 serve lines 1, 14, 15, 16
	for (genvar k = 0; k < 4; k++)
	begin : g_edge
		localparam int PIN = (k == 0) ? 0 : k + 12;
		logic             cmode;
		logic             deb_on;
		logic [DEB_W-1:0] deb_cnt_ff;

		assign cmode  = (k == 1 || k == 2) ? cnt_mode_ff[(k == 2) ? 1 : 0] : 1'b0;
		assign deb_on = edge_cfg_ff[4*k + `GEC_DEB_EN_POS] & ~cmode;

		// Debounce filter; a bounce restarts the hold count
		always_ff @(posedge i_clk or posedge i_rst)
			if (i_rst)
			begin
				filt_ff[k] <= 1'b0;
				deb_cnt_ff <= '0;
			end
			else if (!deb_on)
			begin
				filt_ff[k] <= lvl_ff[PIN];
				deb_cnt_ff <= '0;
			end
			else if (lvl_ff[PIN] == filt_ff[k])
				deb_cnt_ff <= '0;
			else if (deb_cnt_ff == DEB_W'(DEB_CYCLES - 1))
			begin
				filt_ff[k] <= lvl_ff[PIN];
				deb_cnt_ff <= '0;
			end
			else
				deb_cnt_ff <= deb_cnt_ff + 1'b1;

		// Previous filtered level for edge detection
		always_ff @(posedge i_clk or posedge i_rst)
			if (i_rst)
				prev_ff[k] <= 1'b0;
			else
				prev_ff[k] <= filt_ff[k];

		assign rise_w[k] = filt_ff[k] & ~prev_ff[k];
		assign fall_w[k] = ~filt_ff[k] & prev_ff[k];
		// Per-edge events only outside counter mode
		assign edge_evt[k] = fn_en_ff[k] & ~cmode &
			((rise_w[k] & edge_cfg_ff[4*k + `GEC_NOTIFY_RISE]) |
			 (fall_w[k] & edge_cfg_ff[4*k + `GEC_NOTIFY_FALL]));
	end

	// Pulse counters on lines 14 and 15; unfiltered, one edge per cycle max
	for (genvar c = 0; c < 2; c++)
	begin : g_cnt
		logic        counting;
		logic        hit;
		logic [15:0] expiry;

		assign expiry   = cnt_exp_ff[16*c +: 16];
		assign counting = fn_en_ff[c+1] & cnt_mode_ff[c] &
			((rise_w[c+1] & cnt_cfg_ff[4*c + `GEC_NOTIFY_RISE]) |
			 (fall_w[c+1] & cnt_cfg_ff[4*c + `GEC_NOTIFY_FALL]));
		// A stopped one-shot counter sits at the expiry and counts no more
		assign hit = counting && expiry != 16'h0000 && cnt_ff[c] != expiry
			&& (cnt_ff[c] + 16'h0001) == expiry;
		assign cnt_evt[c] = hit;

		always_ff @(posedge i_clk or posedge i_rst)
			if (i_rst)
				cnt_ff[c] <= 16'h0000;
			else if (cnt_clr[c])
				cnt_ff[c] <= 16'h0000;
			else if (hit)
				cnt_ff[c] <= cnt_cfg_ff[4*c + `GEC_CYCLIC_POS] ? 16'h0000 : expiry;
			else if (counting && cnt_ff[c] != expiry)
				cnt_ff[c] <= cnt_ff[c] + 16'h0001;
	end

	// Converter 4 s base tick
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
		end
		else if (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1))
		begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b1;
		end
		else
		begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
			tick_ff     <= 1'b0;
		end

	// Periodic report every N ticks; N of zero treated as one
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			per_cnt_ff <= 8'h00;
			per_evt_ff <= 1'b0;
		end
		else if (!adc_ctrl_ff[`GEC_ADC_PER_EN])
		begin
			per_cnt_ff <= 8'h00;
			per_evt_ff <= 1'b0;
		end
		else if (tick_ff && (per_cnt_ff + 8'h01) >= adc_ctrl_ff[`GEC_ADC_PER_POS +: 8])
		begin
			per_cnt_ff <= 8'h00;
			per_evt_ff <= 1'b1;
		end
		else
		begin
			per_cnt_ff <= tick_ff ? per_cnt_ff + 8'h01 : per_cnt_ff;
			per_evt_ff <= 1'b0;
		end

	// Threshold watch per channel; the range gives hysteresis so one crossing reports once
	for (genvar a = 0; a < 3; a++)
	begin : g_thr
		logic       lo_arm_ff;
		logic       hi_arm_ff;
		logic       chk;
		logic [7:0] val;

		assign val = i_adc_result[a];
		assign chk = tick_ff & adc_ctrl_ff[`GEC_ADC_THR_EN];
		assign low_evt[a]  = chk & lo_arm_ff & (val < adc_lim_ff[7:0]);
		assign high_evt[a] = chk & hi_arm_ff & (val > adc_lim_ff[31:24]);

		always_ff @(posedge i_clk or posedge i_rst)
			if (i_rst)
			begin
				lo_arm_ff <= 1'b1;
				hi_arm_ff <= 1'b1;
			end
			else if (chk)
			begin
				if (low_evt[a])
					lo_arm_ff <= 1'b0;
				else if (val > adc_lim_ff[15:8])
					lo_arm_ff <= 1'b1;
				if (high_evt[a])
					hi_arm_ff <= 1'b0;
				else if (val < adc_lim_ff[23:16])
					hi_arm_ff <= 1'b1;
			end
	end

	// Sticky status: a read clears only bits it returned, and a new set wins
	always_comb
	begin
		nxt_status = status_ff;
		if (rd_go && i_av.address == `GEC_OFS_IRQ_STATUS)
			nxt_status = nxt_status & ~rdata_ff[ST_W-1:0];
		nxt_status = nxt_status | {high_evt, low_evt, per_evt_ff, cnt_evt, edge_evt};
	end

	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			status_ff <= '0;
			irq_ff    <= 1'b0;
		end
		else
		begin
			status_ff <= nxt_status;
			irq_ff    <= |(nxt_status & mask_ff);
		end

	// Watchdog: cannot be switched off once active
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			wdog_act_ff <= 1'b0;
			wdog_cnt_ff <= '0;
			restart_ff  <= 1'b0;
		end
		else
		begin
			restart_ff <= 1'b0;
			if (wr_go && i_av.address == `GEC_OFS_WDOG && i_av.byteenable[0])
			begin
				if (i_av.writedata[`GEC_WDOG_ACT_POS])
					wdog_act_ff <= 1'b1;
				if (i_av.writedata[`GEC_WDOG_KICK_POS] || !wdog_act_ff)
					wdog_cnt_ff <= '0;
			end
			else if (!wdog_act_ff)
				wdog_cnt_ff <= '0;
			else if (wdog_cnt_ff == WDOG_W'(WDOG_CYCLES - 1))
			begin
				wdog_cnt_ff <= '0;
				restart_ff  <= 1'b1;
			end
			else
				wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
		end

	// Outputs straight from flops
	assign o_av_waitrequest = wait_ff;
	assign o_av_readdata    = rdata_ff;
	assign o_gpio_out       = out_data_ff;
	assign o_gpio_oe        = dir_ff;
	assign o_irq            = irq_ff;
	assign o_sys_restart    = restart_ff;

endmodule

//--- gec_gpio_props.sv
`timescale 1ns/10ps
`include "gec_defs.svh"
module gec_gpio_props
	import gec_pkg::*;
#(
	parameter int LINES       = 16,
	parameter int WDOG_CYCLES = 50
) (
	// Clock and reset
	input wire logic                  i_clk,
	input wire logic                  i_rst,
	// Register bus
	input wire gec_pkg::gec_av_req_t  i_av,
	input wire logic                  o_av_waitrequest,
	input wire logic [31:0]           o_av_readdata,
	// Lines and events
	input wire logic [LINES-1:0]      o_gpio_out,
	input wire logic [LINES-1:0]      o_gpio_oe,
	input wire logic                  o_irq,
	input wire logic                  o_sys_restart
);
	logic [31:0] wd_age_ff;
	logic        wd_on_ff;
	logic        ack;
	logic        wd_wr;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Completed access in this cycle
	assign ack   = (i_av.read || i_av.write) && !o_av_waitrequest;
	assign wd_wr = ack && i_av.write && i_av.address == `GEC_OFS_WDOG && i_av.byteenable[0];

	// Age since the timer restarted: activation, kick or expiry; re-activating does not restart
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wd_age_ff <= '0;
			wd_on_ff  <= 1'b0;
		end
		else
		begin
			if (wd_wr && i_av.writedata[0])
				wd_on_ff <= 1'b1;
			if ((wd_wr && (i_av.writedata[1] || !wd_on_ff)) || o_sys_restart)
				wd_age_ff <= '0;
			else if (wd_age_ff != 32'hFFFF_FFFF)
				wd_age_ff <= wd_age_ff + 32'h0000_0001;
		end
	end

	a_bus_answer: assert property ((i_av.read || i_av.write) && o_av_waitrequest |=> !o_av_waitrequest)
		else $error("bus request not answered in one cycle");
	a_ack_single: assert property (!o_av_waitrequest |=> o_av_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_ack_needs_req: assert property ($fell(o_av_waitrequest) |-> $past(i_av.read || i_av.write))
		else $error("acknowledge without a request");
	a_unmapped_zero: assert property (ack && i_av.read && i_av.address > `GEC_OFS_WDOG |-> o_av_readdata == 32'h0000_0000)
		else $error("unmapped read returned data");
	a_out_by_write: assert property ($changed(o_gpio_out) |-> $past(ack && i_av.write && i_av.address == `GEC_OFS_OUT_DATA))
		else $error("output data changed without a write");
	a_dir_by_write: assert property ($changed(o_gpio_oe) |-> $past(ack && i_av.write && i_av.address == `GEC_OFS_DIRECTION))
		else $error("direction changed without a write");
	a_irq_drop_cause: assert property ($fell(o_irq) |-> $past(ack, 1) || $past(ack, 2) || $past(ack, 3))
		else $error("interrupt dropped without a register access");
	a_restart_pulse: assert property (o_sys_restart |=> !o_sys_restart)
		else $error("restart pulse longer than one cycle");
	a_restart_age: assert property (o_sys_restart |-> wd_age_ff >= WDOG_CYCLES - 2)
		else $error("restart before the watchdog interval ran out");
endmodule

bind gec_gpio_monitor gec_gpio_props #(.LINES(LINES), .WDOG_CYCLES(WDOG_CYCLES)) u_props (
	.i_clk(i_clk), .i_rst(i_rst), .i_av(i_av), .o_av_waitrequest(o_av_waitrequest),
	.o_av_readdata(o_av_readdata), .o_gpio_out(o_gpio_out), .o_gpio_oe(o_gpio_oe),
	.o_irq(o_irq), .o_sys_restart(o_sys_restart));

//--- gec_ext_src.sv
`timescale 1ns/10ps
module gec_ext_src
	import gec_pkg::*;
(
	// Clock
	input wire logic                  i_clk,
	// Wanted outside levels and voltages
	input wire logic [15:0]           i_ext_lvl,
	input wire gec_pkg::gec_adc_vec_t i_ext_adc,
	// Device pin drive
	input wire logic [15:0]           i_out,
	input wire logic [15:0]           i_oe,
	// Seen by the device
	output logic [15:0]               o_pin,
	output gec_pkg::gec_adc_vec_t     o_adc
);
	logic [15:0]  ext_ff;
	gec_adc_vec_t adc_ff;

	// Outside world settles one clock after being asked
	always_ff @(posedge i_clk)
	begin
		ext_ff <= i_ext_lvl;
		adc_ff <= i_ext_adc;
	end

	// A driven pin shows the device level, so loopback is seen by the reader
	assign o_pin = (i_out & i_oe) | (ext_ff & ~i_oe);
	assign o_adc = adc_ff;
endmodule

//--- testbench.sv
`timescale 1ns/10ps
`include "gec_defs.svh"
module testbench;
	import gec_pkg::*;
	localparam int WD = 50;
	logic         i_clk, i_rst, wt, irq, rst_o;
	gec_av_req_t  av;
	logic [31:0]  rdat, q;
	logic [15:0]  pin, out, oe, lvl, wo, wdir;
	gec_adc_vec_t adc, adc_in;
	int           num_errors, tests_run, seed, n;

	gec_gpio_monitor #(.DEB_CYCLES(4), .TICK_CYCLES(20), .WDOG_CYCLES(WD)) dut_u (
		.i_clk(i_clk), .i_rst(i_rst), .i_av(av), .o_av_waitrequest(wt), .o_av_readdata(rdat),
		.i_gpio_in(pin), .o_gpio_out(out), .o_gpio_oe(oe), .i_adc_result(adc),
		.o_irq(irq), .o_sys_restart(rst_o));
	gec_ext_src ext_u (.i_clk(i_clk), .i_ext_lvl(lvl), .i_ext_adc(adc_in), .i_out(out),
		.i_oe(oe), .o_pin(pin), .o_adc(adc));

	// Clock and hang guard
	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	initial
	begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		stop_test();
	end

	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("FAIL %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask
	task chk_bit(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e)
		begin
			$display("FAIL %s expected %b seen %b", nm, e, g);
			num_errors++;
		end
	endtask
	// One access; request held until waitrequest is seen low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		av <= '{~w, w, a, 4'hF, d};
		for (k = 0; k < 20; k++)
		begin
			@(posedge i_clk);
			if (wt === 1'b0)
				break;
		end
		if (k == 20)
		begin
			num_errors++;
			stop_test();
		end
		q = rdat;
		av <= '0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0000_0000);
		chk_reg(nm, e, q);
	endtask
	task idle(input int c);
		repeat (c) @(posedge i_clk);
	endtask
	// Two-cycle levels, far above the 2 kHz the counter must take
	task pulses(input int c, input int ln);
		repeat (c)
		begin
			lvl[ln] <= 1'b1;
			idle(2);
			lvl[ln] <= 1'b0;
			idle(2);
		end
	endtask
	task done(input string nm);
		$display("test %s finished", nm);
	endtask
	function automatic logic [31:0] pin_exp(logic [15:0] o, logic [15:0] d, logic [15:0] l);
		pin_exp = {16'h0000, (o & d) | (l & ~d)};
	endfunction
	// Periodic bit plus one limit bit per channel outside the default ranges
	function automatic logic [31:0] thr_exp(gec_adc_vec_t v);
		thr_exp = 32'h0000_0040;
		for (int c = 0; c < 3; c++)
		begin
			if (v[c] < 8'h32)
				thr_exp[7+c] = 1'b1;
			if (v[c] > 8'hC8)
				thr_exp[10+c] = 1'b1;
		end
	endfunction

	// Main sequence
	initial
	begin
		seed = 32'h5afc_ccd1;
		av = '0;
		lvl = '0;
		adc_in = '0;
		i_rst = 1'b1;
		num_errors = 0;
		tests_run = 0;
		idle(8);
		i_rst <= 1'b0;
		rd(`GEC_OFS_EDGE_CFG, 32'h0000_7777, "edge cfg");
		rd(`GEC_OFS_CNT_CFG, 32'h0000_0077, "count cfg");
		rd(`GEC_OFS_CNT_EXPIRY, 32'h0032_0032, "expiry");
		rd(`GEC_OFS_ADC_CTRL, 32'h0000_0100, "adc ctrl");
		rd(`GEC_OFS_ADC_LIMITS, 32'hC8BE_3C32, "limits");
		rd(`GEC_OFS_WDOG, 32'h0000_0000, "wdog off");
		rd(8'h3C, 32'h0000_0000, "unmapped");
		done("reset");
		repeat (4)
		begin
			n = $random(seed);
			lvl <= n[15:0];
			n = $random(seed);
			wo = n[15:0];
			n = $random(seed);
			wdir = n[15:0];
			bus(1'b1, `GEC_OFS_OUT_DATA, {16'h0000, wo});
			bus(1'b1, `GEC_OFS_DIRECTION, {16'h0000, wdir});
			idle(6);
			chk_reg("out dir", {wo, wdir}, {out, oe});
			rd(`GEC_OFS_PIN_LEVEL, pin_exp(wo, wdir, lvl), "pin level");
		end
		bus(1'b1, `GEC_OFS_DIRECTION, 32'h0000_0000);
		lvl <= '0;
		idle(8);
		done("lines");
		bus(1'b1, `GEC_OFS_EDGE_CFG, 32'h0000_7775);
		bus(1'b1, `GEC_OFS_FN_ENABLE, 32'h0000_0001);
		lvl <= 16'h1003;
		idle(2);
		lvl <= 16'h1002;
		idle(12);
		rd(`GEC_OFS_IRQ_STATUS, 32'h0000_0000, "glitch");
		lvl[0] <= 1'b1;
		idle(12);
		chk_bit("irq masked", 1'b0, irq);
		bus(1'b1, `GEC_OFS_IRQ_MASK, 32'h0000_0001);
		idle(3);
		chk_bit("irq", 1'b1, irq);
		rd(`GEC_OFS_IRQ_STATUS, 32'h0000_0001, "rise");
		idle(3);
		chk_bit("irq cleared", 1'b0, irq);
		lvl[0] <= 1'b0;
		idle(12);
		rd(`GEC_OFS_IRQ_STATUS, 32'h0000_0000, "fall");
		done("edge");
		bus(1'b1, `GEC_OFS_FN_ENABLE, 32'h0000_0012);
		bus(1'b1, `GEC_OFS_IRQ_MASK, 32'h0000_0012);
		pulses(24, 13);
		idle(6);
		rd(`GEC_OFS_CNT_VALUE, 32'h0000_0030, "count");
		rd(`GEC_OFS_IRQ_STATUS, 32'h0000_0000, "no edge");
		pulses(1, 13);
		idle(6);
		chk_bit("irq expiry", 1'b1, irq);
		rd(`GEC_OFS_IRQ_STATUS, 32'h0000_0010, "expiry");
		rd(`GEC_OFS_CNT_VALUE, 32'h0000_0000, "cyclic");
		pulses(3, 13);
		idle(6);
		rd(`GEC_OFS_CNT_VALUE, 32'h0000_0006, "partial");
		bus(1'b1, `GEC_OFS_CNT_VALUE, 32'h0000_0001);
		rd(`GEC_OFS_CNT_VALUE, 32'h0000_0000, "cleared");
		// Second counter, one-shot with expiry 4: stops at 4 on the fourth of six edges
		bus(1'b1, `GEC_OFS_CNT_CFG, 32'h0000_0037);
		bus(1'b1, `GEC_OFS_CNT_EXPIRY, 32'h0004_0032);
		bus(1'b1, `GEC_OFS_FN_ENABLE, 32'h0000_0024);
		bus(1'b1, `GEC_OFS_IRQ_MASK, 32'h0000_0020);
		pulses(3, 14);
		idle(6);
		chk_bit("irq one-shot", 1'b1, irq);
		rd(`GEC_OFS_IRQ_STATUS, 32'h0000_0020, "one-shot expiry");
		rd(`GEC_OFS_CNT_VALUE, 32'h0004_0000, "one-shot stop");
		done("counter");
		n = $random(seed);
		adc_in <= {8'hC9, n[7:0], 8'h31};
		idle(50);
		rd(`GEC_OFS_ADC_VALUE, {8'h00, adc_in}, "adc value");
		rd(`GEC_OFS_IRQ_STATUS, 32'h0000_0000, "adc off");
		bus(1'b1, `GEC_OFS_ADC_CTRL, 32'h0000_0103);
		idle(24);
		rd(`GEC_OFS_IRQ_STATUS, thr_exp(adc_in), "adc notify");
		done("adc");
		bus(1'b1, `GEC_OFS_WDOG, 32'h0000_0001);
		rd(`GEC_OFS_WDOG, 32'h0000_0001, "wdog on");
		idle(20);
		bus(1'b1, `GEC_OFS_WDOG, 32'h0000_0002);
		for (n = 0; n < 100 && rst_o !== 1'b1; n++)
			@(posedge i_clk);
		chk_bit("restart time", 1'b1, n >= WD - 4 && n <= WD + 2);
		done("wdog");
		stop_test();
	end
endmodule
